// [logic/updown_counter_pkg.sv]
`default_nettype none

package updown_counter_pkg;

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam int          COUNT_WIDTH = 4;
    localparam logic [3:0]  COUNT_RESET = 4'h0;
    localparam logic [3:0]  COUNT_ZERO  = 4'h0;
    localparam logic [3:0]  MAX_DECADE  = 4'h9;
    localparam logic [3:0]  MAX_BINARY  = 4'hF;
    localparam logic        TC_RESET    = 1'b0;
    localparam logic        RC_N_RESET  = 1'b1;
    localparam logic        CLK_RESET   = 1'b0;

    // ------------------------------------------------------------
    // control inputs from the controller or earlier stage
    // ------------------------------------------------------------
    typedef struct packed {
        logic parallel_load_n;
        logic count_enable_n;
        logic count_down;
    } count_ctrl_t;

endpackage

`default_nettype wire

// [logic/presettable_up_down_counter.sv]
// Functional notes
// - while load low, preset data is copied into the count and shown
// - load overrides clock, enable and direction
// - with load high and enable low, count changes only on count clock rise
// - with enable high the count holds
// - direction low: each count clock rise increments
// - direction high: each count clock rise decrements
// - terminal count high at zero counting down, at maximum counting up
// - terminal count follows state and direction only, stays until they change
// - ripple clock rests high, pulses low in clock low phase when enabled at terminal
// - terminal count ignores this stage's own enable
`timescale 1ns/10ps
`default_nettype none

module presettable_up_down_counter #(
    parameter logic [3:0] MAX_COUNT = updown_counter_pkg::MAX_DECADE
) (
    input  wire logic                             clock,
    input  wire logic                             rst_n,
    input  wire logic                             count_clock,
    input  wire updown_counter_pkg::count_ctrl_t  ctrl,
    input  wire logic [3:0]                       preset_data,
    output logic [3:0]                            count_outputs,
    output logic                                  terminal_count,
    output logic                                  ripple_clock_n
);

    // ------------------------------------------------------------
    // count clock edge detection
    // ------------------------------------------------------------
    logic       count_clock_q;
    logic       count_rise;
    logic [3:0] count_d;
    logic       tc_d;
    logic       rc_n_d;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count_clock_q <= updown_counter_pkg::CLK_RESET;
        end else begin
            count_clock_q <= count_clock;
        end
    end

    // reset value low: a count clock already high at release reads as one rise
    assign count_rise = count_clock & ~count_clock_q;

    // ------------------------------------------------------------
    // next count
    // ------------------------------------------------------------
    // load is sampled on the system clock, so it lands one cycle late
    // decade values above nine, only reachable by load, wrap to zero counting up
    always_comb begin
        count_d = count_outputs;
        if (!ctrl.parallel_load_n) begin
            count_d = preset_data;
        end else if (!ctrl.count_enable_n && count_rise) begin
            if (!ctrl.count_down) begin
                if (count_outputs >= MAX_COUNT) begin
                    count_d = updown_counter_pkg::COUNT_ZERO;
                end else begin
                    count_d = count_outputs + 4'h1;
                end
            end else begin
                if (count_outputs == updown_counter_pkg::COUNT_ZERO) begin
                    count_d = MAX_COUNT;
                end else begin
                    count_d = count_outputs - 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count_outputs <= updown_counter_pkg::COUNT_RESET;
        end else begin
            count_outputs <= count_d;
        end
    end

    // ------------------------------------------------------------
    // terminal count
    // ------------------------------------------------------------
    // decoded from the next state so it lines up with the count outputs
    assign tc_d = ctrl.count_down ? (count_d == updown_counter_pkg::COUNT_ZERO)
                                  : (count_d == MAX_COUNT);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            terminal_count <= updown_counter_pkg::TC_RESET;
        end else begin
            terminal_count <= tc_d;
        end
    end

    // ------------------------------------------------------------
    // ripple clock
    // ------------------------------------------------------------
    // registered, so it is glitch free like terminal count
    // follows the sampled count clock, one cycle behind the pin
    assign rc_n_d = ~(~ctrl.count_enable_n & terminal_count & ~count_clock);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ripple_clock_n <= updown_counter_pkg::RC_N_RESET;
        end else begin
            ripple_clock_n <= rc_n_d;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    property p_load_copies;
        !ctrl.parallel_load_n |=> count_outputs == $past(preset_data);
    endproperty
    a_load_copies: assert property (p_load_copies) else $error("load did not copy preset");

    property p_load_priority;
        (!ctrl.parallel_load_n && !ctrl.count_enable_n && count_rise)
            |=> count_outputs == $past(preset_data);
    endproperty
    a_load_priority: assert property (p_load_priority) else $error("counting beat load");

    property p_no_rise_hold;
        (ctrl.parallel_load_n && !count_rise) |=> $stable(count_outputs);
    endproperty
    a_no_rise_hold: assert property (p_no_rise_hold) else $error("count moved without clock rise");

    property p_disable_hold;
        (ctrl.parallel_load_n && ctrl.count_enable_n) |=> $stable(count_outputs);
    endproperty
    a_disable_hold: assert property (p_disable_hold) else $error("count moved while disabled");

    property p_count_up;
        (ctrl.parallel_load_n && !ctrl.count_enable_n && count_rise && !ctrl.count_down
            && count_outputs < MAX_COUNT)
            |=> count_outputs == $past(count_outputs) + 4'h1;
    endproperty
    a_count_up: assert property (p_count_up) else $error("up count wrong");

    property p_count_down;
        (ctrl.parallel_load_n && !ctrl.count_enable_n && count_rise && ctrl.count_down
            && count_outputs != updown_counter_pkg::COUNT_ZERO)
            |=> count_outputs == $past(count_outputs) - 4'h1;
    endproperty
    a_count_down: assert property (p_count_down) else $error("down count wrong");

    property p_tc_decode;
        $past(rst_n) |-> terminal_count == ($past(ctrl.count_down)
            ? (count_outputs == updown_counter_pkg::COUNT_ZERO) : (count_outputs == MAX_COUNT));
    endproperty
    a_tc_decode: assert property (p_tc_decode) else $error("terminal count decode wrong");

    property p_tc_stable;
        ($past(rst_n) && $stable(count_outputs) && $past(ctrl.count_down) == $past(ctrl.count_down, 2))
            |-> $stable(terminal_count);
    endproperty
    a_tc_stable: assert property (p_tc_stable) else $error("terminal count changed alone");

    property p_rc_pulse;
        !ripple_clock_n |-> $past(!ctrl.count_enable_n && !count_clock && terminal_count);
    endproperty
    a_rc_pulse: assert property (p_rc_pulse) else $error("ripple clock low without cause");

    property p_rc_low;
        (!ctrl.count_enable_n && terminal_count && !count_clock) |=> !ripple_clock_n;
    endproperty
    a_rc_low: assert property (p_rc_low) else $error("ripple clock missed pulse");

    property p_wrap_up;
        (ctrl.parallel_load_n && !ctrl.count_enable_n && count_rise && !ctrl.count_down
            && count_outputs == MAX_COUNT) |=> count_outputs == updown_counter_pkg::COUNT_ZERO;
    endproperty
    a_wrap_up: assert property (p_wrap_up) else $error("up wrap wrong");

    property p_wrap_down;
        (ctrl.parallel_load_n && !ctrl.count_enable_n && count_rise && ctrl.count_down
            && count_outputs == updown_counter_pkg::COUNT_ZERO) |=> count_outputs == MAX_COUNT;
    endproperty
    a_wrap_down: assert property (p_wrap_down) else $error("down wrap wrong");

    property p_rc_rest;
        ctrl.count_enable_n |=> ripple_clock_n;
    endproperty
    a_rc_rest: assert property (p_rc_rest) else $error("ripple clock pulsed while disabled");

    property p_tc_mid;
        (count_outputs != updown_counter_pkg::COUNT_ZERO && count_outputs != MAX_COUNT)
            |-> !terminal_count;
    endproperty
    a_tc_mid: assert property (p_tc_mid) else $error("terminal count high mid range");

    property p_load_tc;
        !ctrl.parallel_load_n |=> terminal_count == ($past(ctrl.count_down)
            ? ($past(preset_data) == updown_counter_pkg::COUNT_ZERO) : ($past(preset_data) == MAX_COUNT));
    endproperty
    a_load_tc: assert property (p_load_tc) else $error("terminal count missed loaded state");

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------
    c_wrap_up: cover property (p_wrap_up);
    c_rc_pulse: cover property (!ripple_clock_n ##1 ripple_clock_n);
    c_load: cover property (!ctrl.parallel_load_n ##1 ctrl.parallel_load_n);
    c_count_down: cover property (ctrl.parallel_load_n && !ctrl.count_enable_n && count_rise && ctrl.count_down);
    c_tc_rise: cover property (!terminal_count ##1 terminal_count);

endmodule
`default_nettype wire

// [verification/count_driver.sv]
`timescale 1ns/10ps
`default_nettype none

// stands in for the controller; never clocks anything from terminal count
// one stage only: clock low phase ample, en_req acts as the global enable
module count_driver (
    input  wire logic                       clock,
    input  wire logic                       load_req,
    input  wire logic                       en_req,
    input  wire logic                       down_req,
    output logic                            count_clock,
    output updown_counter_pkg::count_ctrl_t ctrl
);
    logic [1:0] ph_q = 2'h0;

    assign count_clock = ph_q[1];

    initial ctrl = 3'h6;

    always @(posedge clock) begin
        ph_q <= #1 ph_q + 2'h1;
        ctrl.parallel_load_n <= #1 ~load_req;
        // enable and direction move only mid high phase, never near an edge
        if (ph_q == 2'h2) begin
            ctrl.count_enable_n <= #1 ~en_req;
            ctrl.count_down     <= #1 down_req;
        end
    end
endmodule
`default_nettype wire

// [verification/presettable_up_down_counter_test.sv]
`timescale 1ns/10ps
`default_nettype none

module presettable_up_down_counter_test;
    logic clock = 1'b0, rst_n = 1'b0, load_req = 1'b0, en_req = 1'b0, down_req = 1'b0, count_clock;
    logic [3:0] preset = 4'h0, v;
    updown_counter_pkg::count_ctrl_t ctrl;
    logic [3:0] cnt[2], exp_c[2] = '{4'h0, 4'h0}, nq[2][$];
    logic [3:0] mx[2] = '{updown_counter_pkg::MAX_DECADE, updown_counter_pkg::MAX_BINARY};
    logic tc[2], rc_n[2];
    int err_total = 0, n_compared = 0, cyc = 0, rc_low[2] = '{0, 0};

    initial forever #25 clock = ~clock;

    count_driver PM (.clock(clock), .load_req(load_req), .en_req(en_req), .down_req(down_req),
        .count_clock(count_clock), .ctrl(ctrl));

    task automatic check(input logic [3:0] seen, input logic [3:0] want);
        n_compared++;
        if (seen !== want) begin
            err_total++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask

    // ------------------------------------------------------------
    // decade and binary stages side by side, each with its monitor
    // ------------------------------------------------------------
    for (genvar k = 0; k < 2; k++) begin : g
        logic [3:0] prev_q = 4'h0;
        presettable_up_down_counter #(.MAX_COUNT(k ? updown_counter_pkg::MAX_BINARY : updown_counter_pkg::MAX_DECADE))
        DUT (.clock(clock), .rst_n(rst_n), .count_clock(count_clock), .ctrl(ctrl), .preset_data(preset),
            .count_outputs(cnt[k]), .terminal_count(tc[k]), .ripple_clock_n(rc_n[k]));
        always @(posedge clock) begin
            prev_q <= cnt[k];
            if (rst_n && rc_n[k] === 1'b0) rc_low[k]++;
            // any change with no note pending is a spurious count
            if (rst_n && cnt[k] !== prev_q) begin
                if (nq[k].size() == 0) check(cnt[k], ~cnt[k]);
                else check(cnt[k], nq[k].pop_front());
            end
        end
    end

    function automatic logic [3:0] nxt(int k, logic [3:0] c, logic dn);
        return dn ? (c == 4'h0 ? mx[k] : c - 4'h1) : (c == mx[k] ? 4'h0 : c + 4'h1);
    endfunction

    function automatic logic at_tc(int k, logic [3:0] c, logic dn);
        return dn ? c == 4'h0 : c == mx[k];
    endfunction

    task automatic load(input logic [3:0] d);
        @(posedge clock);
        #1 preset = d;
        load_req = 1'b1;
        en_req = 1'b1;
        for (int k = 0; k < 2; k++) begin
            exp_c[k] = d;
            nq[k].push_back(d);
        end
        // counting edges arrive meanwhile and must be ignored
        repeat (10) @(posedge clock);
        #1 en_req = 1'b0;
        repeat (6) @(posedge clock);
        #1 load_req = 1'b0;
        repeat (4) @(posedge clock);
        $display("load %h done", d);
    endtask

    task automatic run(input logic dn, input int n);
        int base[2], e[2], i;
        base = rc_low;
        @(posedge clock);
        #1 down_req = dn;
        en_req = 1'b1;
        for (int k = 0; k < 2; k++) begin
            e[k] = 0;
            for (i = 0; i < n; i++) begin
                if (at_tc(k, exp_c[k], dn)) e[k] += 2;
                exp_c[k] = nxt(k, exp_c[k], dn);
                nq[k].push_back(exp_c[k]);
            end
        end
        for (i = 0; i < 8 && ctrl.count_enable_n !== 1'b0; i++) @(posedge clock);
        repeat (n) @(posedge count_clock);
        #1 en_req = 1'b0;
        repeat (12) @(posedge clock);
        for (int k = 0; k < 2; k++) begin
            check(tc[k], at_tc(k, exp_c[k], dn));
            check(4'(rc_low[k] - base[k]), 4'(e[k]));
            check(4'(nq[k].size()), 4'h0);
        end
        $display("run dir %0d steps %0d done", dn, n);
    endtask

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            $display("BAD %0t timeout", $time);
            test_done;
        end
    end

    initial begin
        void'($urandom(97));
        repeat (12) @(posedge clock);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clock);
        for (int k = 0; k < 2; k++) begin
            check(cnt[k], 4'h0);
            check(tc[k], 1'b0);
            check(rc_n[k], 1'b1);
        end
        // decade stage wraps through nine and back through zero; binary stage only moves between 7 and B
        load(4'h8);
        run(1'b0, 3);
        run(1'b1, 4);
        for (int t = 0; t < 6; t++) begin
            do v = 4'($urandom_range(9)); while (v == exp_c[0] || v == exp_c[1]);
            load(v);
            run(1'($urandom_range(1)), $urandom_range(12, 1));
        end
        test_done;
    end
endmodule
`default_nettype wire
